// ### rtl/dpll_lock_nco.sv
// two-channel phase lock detector and nco tuning-word filter with apb registers
// Function
// - tuning word passes single-pole unity-gain lowpass
// - 4-bit code sets filter corner
// - settling time doubles per bandwidth code
// - new freerun word glides, never jumps
// - each channel has own detector and filter
// - status bit 1 shows live lock
// - sticky bits catch lock and unlock transitions
// - level spans -2048 to +2047, saturating
// - fill and drain rates are 8-bit
// - lock above 1024, unlock below -1025
// - level readable through two byte registers
// - every sample outside freerun and holdover gives exactly one update
// - threshold is 24-bit picoseconds
// - magnitude within threshold fills, else drains
// - slew limiting suppresses fills
// - zero fill rate blocks locking, zero drain rate blocks unlocking except by freerun or holdover
// - freerun or holdover reports unlocked
// - mode bit 0 selects freerun
`timescale 1ns/1ps
`default_nettype none
`include "dpll_lock_params.svh"

module dpll_lock_nco #(
  parameter int TW_W = 48
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire dpll_lock_pkg::phase_sample_t [1:0] PHASE_SAMPLE,
  input wire logic [1:0] SLEW_ACTIVE,
  input wire logic [1:0] HOLDOVER,
  input wire logic [1:0][TW_W-1:0] TW_IN,
  output logic [1:0][TW_W-1:0] TW_OUT,
  output logic [1:0] FREERUN,
  output logic [1:0] PHASE_LOCK
);
  import dpll_lock_pkg::*;

  localparam logic [15:0] IDX_BW [2] = '{`IDX_BW_CH0, `IDX_BW_CH1};
  localparam logic [15:0] IDX_CLR [2] = '{`IDX_CLR_CH0, `IDX_CLR_CH1};
  localparam logic [15:0] IDX_MODE [2] = '{`IDX_MODE_CH0, `IDX_MODE_CH1};
  localparam logic [15:0] IDX_FLAGS [2] = '{`IDX_FLAGS_CH0, `IDX_FLAGS_CH1};
  localparam logic [15:0] IDX_STATUS [2] = '{`IDX_STATUS_CH0, `IDX_STATUS_CH1};
  localparam logic [15:0] IDX_LVL_LO [2] = '{`IDX_LVL_LO_CH0, `IDX_LVL_LO_CH1};
  localparam logic [15:0] IDX_LVL_HI [2] = '{`IDX_LVL_HI_CH0, `IDX_LVL_HI_CH1};
  localparam logic [15:0] IDX_THR [2] = '{`IDX_THR_CH0, `IDX_THR_CH1};
  localparam logic [15:0] IDX_RATE [2] = '{`IDX_RATE_CH0, `IDX_RATE_CH1};
  localparam int FRAC = `TW_FRAC_BITS;
  localparam int ACC_W = TW_W + FRAC;

  function automatic reg_dec_t decode(input logic [15:0] addr);
    reg_dec_t d;
    logic [13:0] w;
    d.hit = 1'b0;
    d.ch = 1'b0;
    d.sel = SEL_NONE;
    w = addr[15:2];
    for (int c = 0; c < 2; c++) begin
      if (w == IDX_BW[c][13:0]) begin
        d.sel = SEL_BW;
        d.ch = c[0];
      end else if (w == IDX_CLR[c][13:0]) begin
        d.sel = SEL_CLR;
        d.ch = c[0];
      end else if (w == IDX_MODE[c][13:0]) begin
        d.sel = SEL_MODE;
        d.ch = c[0];
      end else if (w == IDX_FLAGS[c][13:0]) begin
        d.sel = SEL_FLAGS;
        d.ch = c[0];
      end else if (w == IDX_STATUS[c][13:0]) begin
        d.sel = SEL_STATUS;
        d.ch = c[0];
      end else if (w == IDX_LVL_LO[c][13:0]) begin
        d.sel = SEL_LVL_LO;
        d.ch = c[0];
      end else if (w == IDX_LVL_HI[c][13:0]) begin
        d.sel = SEL_LVL_HI;
        d.ch = c[0];
      end else if (w == IDX_THR[c][13:0]) begin
        d.sel = SEL_THR;
        d.ch = c[0];
      end else if (w == IDX_RATE[c][13:0]) begin
        d.sel = SEL_RATE;
        d.ch = c[0];
      end
    end
    d.hit = (d.sel != SEL_NONE) && (addr[1:0] == 2'b00);
    return d;
  endfunction

  // magnitude ignoring sign; the most negative error maps to 2^31, above any threshold
  function automatic logic [31:0] err_mag(input logic signed [31:0] e);
    logic [31:0] m;
    m = 32'(e);
    if (e[31]) begin
      m = 32'(-e);
    end
    return m;
  endfunction

  // one bucket per sample, clamped at both ends of the tub rather than wrapping
  function automatic logic signed [13:0] level_step(input logic signed [13:0] cur, input logic [7:0] fill,
    input logic [7:0] drain, input logic up);
    logic signed [13:0] nx;
    if (up) begin
      nx = cur + $signed({6'h00, fill});
      if (nx > `LVL_FULL) begin
        nx = `LVL_FULL;
      end
    end else begin
      nx = cur - $signed({6'h00, drain});
      if (nx < `LVL_EMPTY) begin
        nx = `LVL_EMPTY;
      end
    end
    return nx;
  endfunction

  // hysteresis: between the marks the previous indication holds
  function automatic logic lock_mark(input logic signed [13:0] lvl, input logic prev);
    logic r;
    r = prev;
    if (lvl > `LVL_HIGH_MARK) begin
      r = 1'b1;
    end else if (lvl < `LVL_LOW_MARK) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // apb: one wait state, read data and error registered with pready
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic access;
  logic commit;
  reg_dec_t dec;

  assign access = PSEL & PENABLE;
  assign commit = access & pready_q;
  assign dec = decode(PADDR);

  logic [3:0] bw_q [2];
  logic mode_q [2];
  logic [23:0] thr_q [2];
  logic [7:0] fill_q [2];
  logic [7:0] drain_q [2];
  logic [1:0] ev_q [2];
  logic lock_q [2];
  logic signed [13:0] lvl_q [2];
  logic [ACC_W-1:0] acc_q [2];

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (access & ~pready_q) begin
      // refused accesses answer with zero data, even on a mapped but unaligned address
      prdata_q <= (PWRITE | ~dec.hit) ? 32'h0000_0000 : rdata_d;
      pslverr_q <= ~dec.hit;
    end else begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (dec.sel)
      SEL_BW: rdata_d[3:0] = bw_q[dec.ch];
      SEL_MODE: rdata_d[`BIT_MODE_FREERUN] = mode_q[dec.ch];
      SEL_FLAGS: rdata_d[1:0] = ev_q[dec.ch];
      SEL_STATUS: rdata_d[`BIT_STATUS_LOCK] = lock_q[dec.ch];
      SEL_LVL_LO: rdata_d[7:0] = lvl_q[dec.ch][7:0];
      SEL_LVL_HI: rdata_d[7:0] = {{4{lvl_q[dec.ch][11]}}, lvl_q[dec.ch][11:8]};
      SEL_THR: rdata_d[23:0] = thr_q[dec.ch];
      SEL_RATE: rdata_d[15:0] = {drain_q[dec.ch], fill_q[dec.ch]};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      logic wr_hit;
      logic clr_lock;
      logic clr_unlock;
      logic open_loop;
      logic do_fill;
      logic [31:0] mag;
      logic signed [13:0] lvl_d;
      logic lock_d;
      logic lock_nx;
      logic [4:0] shift;
      logic signed [ACC_W:0] diff;
      logic signed [ACC_W:0] step;

      assign wr_hit = commit & PWRITE & dec.hit & (dec.ch == 1'(g));

      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          bw_q[g] <= `RST_BW;
        end else if (wr_hit && dec.sel == SEL_BW) begin
          bw_q[g] <= PWDATA[3:0];
        end
      end

      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          mode_q[g] <= 1'b0;
        end else if (wr_hit && dec.sel == SEL_MODE) begin
          mode_q[g] <= PWDATA[`BIT_MODE_FREERUN];
        end
      end

      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          thr_q[g] <= `RST_THR;
          fill_q[g] <= `RST_FILL;
          drain_q[g] <= `RST_DRAIN;
        end else if (wr_hit && dec.sel == SEL_THR) begin
          thr_q[g] <= PWDATA[23:0];
        end else if (wr_hit && dec.sel == SEL_RATE) begin
          fill_q[g] <= PWDATA[`RATE_FILL_LSB +: 8];
          drain_q[g] <= PWDATA[`RATE_DRAIN_LSB +: 8];
        end
      end

      // filter: unity dc gain, corner halves per code step
      assign shift = bw_q[g] + `FILT_BASE_SHIFT;
      assign diff = $signed({1'b0, TW_IN[g], {FRAC{1'b0}}}) - $signed({1'b0, acc_q[g]});
      assign step = diff >>> shift;

      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          acc_q[g] <= '0;
        end else begin
          acc_q[g] <= acc_q[g] + step[ACC_W-1:0];
        end
      end

      assign open_loop = mode_q[g] | HOLDOVER[g];
      assign mag = err_mag(PHASE_SAMPLE[g].err_ps);
      // slew limiting turns a would-be fill into a drain, so each sample still updates the level by the drain rate
      assign do_fill = (mag <= {8'h00, thr_q[g]}) & ~SLEW_ACTIVE[g];

      always_comb begin
        lvl_d = level_step(lvl_q[g], fill_q[g], drain_q[g], do_fill);
        lock_d = lock_mark(lvl_d, lock_q[g]);
      end

      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          lvl_q[g] <= `LVL_EMPTY;
          lock_q[g] <= 1'b0;
        end else if (open_loop) begin
          lvl_q[g] <= `LVL_EMPTY;
          lock_q[g] <= 1'b0;
        end else if (PHASE_SAMPLE[g].valid) begin
          lvl_q[g] <= lvl_d;
          lock_q[g] <= lock_d;
        end
      end

      assign clr_lock = wr_hit && dec.sel == SEL_CLR && PWDATA[`BIT_EV_LOCKED];
      assign clr_unlock = wr_hit && dec.sel == SEL_CLR && PWDATA[`BIT_EV_UNLOCKED];
      // next lock value exactly as the lock register will take it
      assign lock_nx = open_loop ? 1'b0 : (PHASE_SAMPLE[g].valid ? lock_d : lock_q[g]);

      // a transition in the clearing cycle survives the clear
      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          ev_q[g] <= 2'b00;
        end else begin
          ev_q[g][`BIT_EV_LOCKED] <= (lock_nx & ~lock_q[g]) | (ev_q[g][`BIT_EV_LOCKED] & ~clr_lock);
          ev_q[g][`BIT_EV_UNLOCKED] <= (~lock_nx & lock_q[g]) | (ev_q[g][`BIT_EV_UNLOCKED] & ~clr_unlock);
        end
      end

      always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          TW_OUT[g] <= '0;
          FREERUN[g] <= 1'b0;
          PHASE_LOCK[g] <= 1'b0;
        end else begin
          TW_OUT[g] <= acc_q[g][ACC_W-1:FRAC];
          FREERUN[g] <= mode_q[g];
          PHASE_LOCK[g] <= lock_q[g];
        end
      end
    end
  endgenerate

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

endmodule
`default_nettype wire

// ### shared/dpll_lock_params.svh
// offsets, field positions, reset values and limits of the lock detector and tuning-word filter
`ifndef DPLL_LOCK_PARAMS_SVH
`define DPLL_LOCK_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_BW_CH0 16'h1009
`define IDX_BW_CH1 16'h1409
`define IDX_CLR_CH0 16'h200b
`define IDX_CLR_CH1 16'h2010
`define IDX_MODE_CH0 16'h2105
`define IDX_MODE_CH1 16'h2205
`define IDX_FLAGS_CH0 16'h3010
`define IDX_FLAGS_CH1 16'h3015
`define IDX_STATUS_CH0 16'h3100
`define IDX_STATUS_CH1 16'h3200
`define IDX_LVL_LO_CH0 16'h3109
`define IDX_LVL_LO_CH1 16'h3209
`define IDX_LVL_HI_CH0 16'h310a
`define IDX_LVL_HI_CH1 16'h320a
`define IDX_THR_CH0 16'h0500
`define IDX_THR_CH1 16'h0600
`define IDX_RATE_CH0 16'h0501
`define IDX_RATE_CH1 16'h0601

// field positions
`define BIT_STATUS_LOCK 1
`define BIT_EV_LOCKED 0
`define BIT_EV_UNLOCKED 1
`define BIT_MODE_FREERUN 0
`define RATE_FILL_LSB 0
`define RATE_DRAIN_LSB 8

// reset values
`define RST_BW 4'h0
`define RST_THR 24'h0003e8
`define RST_FILL 8'h01
`define RST_DRAIN 8'h01

// detector level bounds and marks
`define LVL_EMPTY 14'sh3800
`define LVL_FULL 14'sh07ff
`define LVL_HIGH_MARK 14'sh0400
`define LVL_LOW_MARK 14'sh3bff

// filter
`define TW_FRAC_BITS 16
`define FILT_BASE_SHIFT 5'h03

`endif

// ### shared/dpll_lock_pkg.sv
// types shared by the lock detector and tuning-word filter block
package dpll_lock_pkg;

  typedef struct packed {
    logic valid;
    logic signed [31:0] err_ps;
  } phase_sample_t;

  typedef enum {
    SEL_NONE,
    SEL_BW,
    SEL_CLR,
    SEL_MODE,
    SEL_FLAGS,
    SEL_STATUS,
    SEL_LVL_LO,
    SEL_LVL_HI,
    SEL_THR,
    SEL_RATE
  } reg_sel_t;

  typedef struct packed {
    logic hit;
    logic ch;
    reg_sel_t sel;
  } reg_dec_t;

endpackage

// ### verif/dpll_lock_nco_assertions.sv
// port-level checks for the lock detector and tuning-word filter
`timescale 1ns/1ps
`default_nettype none
module dpll_lock_nco_checker #(
  parameter int TW_W = 48
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [1:0] HOLDOVER,
  input wire logic [1:0][TW_W-1:0] TW_IN,
  input wire logic [1:0][TW_W-1:0] TW_OUT,
  input wire logic [1:0] FREERUN,
  input wire logic [1:0] PHASE_LOCK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_ready_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("no answer in second access cycle");
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_ready; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready or with data");
  property p_rdata_idle; !PREADY |-> PRDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer cycle");
  property p_hold_unlock; HOLDOVER[1] |-> ##2 !PHASE_LOCK[1]; endproperty
  a_hold_unlock: assert property (p_hold_unlock)
    else $error("lock shown in holdover");
  property p_free_unlock; FREERUN[0] |=> !PHASE_LOCK[0]; endproperty
  a_free_unlock: assert property (p_free_unlock)
    else $error("lock shown in freerun");
  property p_reset_quiet;
    $rose(RSTN) |-> PHASE_LOCK == 2'b00 && FREERUN == 2'b00 && TW_OUT[0] == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle at reset release");
  // only rising steps: a falling glide may still lag above the target
  property p_glide;
    $changed(TW_IN[0]) && TW_IN[0] > TW_OUT[0] ##1 $stable(TW_IN[0]) |-> TW_OUT[0] < TW_IN[0];
  endproperty
  a_glide: assert property (p_glide)
    else $error("tuning word jumped");
  c_err: cover property (PSLVERR);
  c_lock: cover property ($rose(PHASE_LOCK[0]));
  c_hold: cover property ($fell(PHASE_LOCK[1]));
endmodule
bind dpll_lock_nco dpll_lock_nco_checker #(.TW_W(TW_W)) u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HOLDOVER(HOLDOVER),
  .TW_IN(TW_IN), .TW_OUT(TW_OUT), .FREERUN(FREERUN), .PHASE_LOCK(PHASE_LOCK));
`default_nettype wire

// ### verif/dpll_lock_nco_tb.sv
// self-checking bench: detector, event flags and tuning-word filter
`timescale 1ns/1ps
`default_nettype none
`include "dpll_lock_params.svh"
module dpll_lock_nco_tb;
  import dpll_lock_pkg::*;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, er;
  logic [15:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic [1:0] SLEW_ACTIVE = '0, HOLDOVER = '0, en = '0, FREERUN, PHASE_LOCK;
  logic [1:0][47:0] TW_IN = '0, TW_OUT;
  logic signed [31:0] err = '0;
  logic [3:0] gap = '0;
  phase_sample_t s0, s1;
  int fail_count = 0, n_compared = 0;
  always #50 CLK = ~CLK;
  dpll_lock_nco u_dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PHASE_SAMPLE({s1, s0}), .SLEW_ACTIVE(SLEW_ACTIVE), .HOLDOVER(HOLDOVER), .TW_IN(TW_IN),
    .TW_OUT(TW_OUT), .FREERUN(FREERUN), .PHASE_LOCK(PHASE_LOCK));
  phase_source_model u_src0 (.clk(CLK), .en(en[0]), .gap(gap), .err(err), .smp(s0));
  phase_source_model u_src1 (.clk(CLK), .en(en[1]), .gap(gap), .err(err), .smp(s1));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx[13:0], 2'b00};
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task automatic lvl(input logic signed [11:0] v);
    rc(`IDX_LVL_LO_CH0, {24'h0, v[7:0]});
    rc(`IDX_LVL_HI_CH0, {24'h0, {4{v[11]}}, v[11:8]});
  endtask
  // one sample per gap+1 cycles, n samples in all
  task automatic feed(input int ch, input int n);
    @(posedge CLK);
    en[ch] <= 1'b1;
    repeat (n * (gap + 1)) @(posedge CLK);
    en[ch] <= 1'b0;
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end
  initial begin
    repeat (5) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    apb(1'b1, `IDX_FLAGS_CH0, 32'hff);
    rc(`IDX_FLAGS_CH0, 32'h0);
    rc(`IDX_STATUS_CH0, 32'h0);
    lvl(-12'sd2048);
    rc(`IDX_BW_CH0, 32'h0);
    apb(1'b0, 16'h0123, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `IDX_THR_CH0, 32'd1000);
    apb(1'b1, `IDX_RATE_CH0, 32'h80ff);
    err <= -32'sd1000;
    feed(0, 12);
    lvl(12'sd1012);
    rc(`IDX_STATUS_CH0, 32'h0);
    feed(0, 1);
    rc(`IDX_STATUS_CH0, 32'h2);
    chk({30'h0, PHASE_LOCK}, 32'h1);
    rc(`IDX_FLAGS_CH0, 32'h1);
    feed(0, 7);
    lvl(12'sd2047);
    err <= 32'sd1001;
    feed(0, 24);
    rc(`IDX_STATUS_CH0, 32'h2);
    lvl(-12'sd1025);
    gap <= 4'h3;
    feed(0, 1);
    rc(`IDX_STATUS_CH0, 32'h0);
    rc(`IDX_FLAGS_CH0, 32'h3);
    apb(1'b1, `IDX_CLR_CH0, 32'h1);
    rc(`IDX_FLAGS_CH0, 32'h2);
    apb(1'b1, `IDX_CLR_CH0, 32'h2);
    rc(`IDX_FLAGS_CH0, 32'h0);
    gap <= 4'h0;
    err <= 32'sd0;
    SLEW_ACTIVE[0] <= 1'b1;
    feed(0, 8);
    lvl(-12'sd2048);
    SLEW_ACTIVE[0] <= 1'b0;
    feed(0, 13);
    apb(1'b1, `IDX_MODE_CH0, 32'h1);
    rc(`IDX_STATUS_CH0, 32'h0);
    chk({30'h0, FREERUN}, 32'h1);
    rc(`IDX_FLAGS_CH0, 32'h3);
    feed(0, 13);
    lvl(-12'sd2048);
    apb(1'b1, `IDX_MODE_CH0, 32'h0);
    apb(1'b1, `IDX_RATE_CH1, 32'h00ff);
    feed(1, 13);
    rc(`IDX_STATUS_CH1, 32'h2);
    rc(`IDX_LVL_LO_CH1, 32'hf3);
    // zero drain: errors far above threshold must not lower the level
    err <= 32'sd5000;
    feed(1, 4);
    rc(`IDX_LVL_LO_CH1, 32'hf3);
    rc(`IDX_STATUS_CH1, 32'h2);
    HOLDOVER[1] <= 1'b1;
    repeat (3) @(posedge CLK);
    chk({30'h0, PHASE_LOCK}, 32'h0);
    rc(`IDX_FLAGS_CH1, 32'h3);
    HOLDOVER[1] <= 1'b0;
    // step of 2^32 at code 0 must be within 1 percent after 40 cycles
    TW_IN[0] <= 48'h1_0000_0000;
    repeat (40) @(posedge CLK);
    chk({31'h0, (TW_IN[0] - TW_OUT[0]) * 100 <= TW_IN[0]}, 32'h1);
    apb(1'b1, `IDX_BW_CH0, 32'h1);
    TW_IN[0] <= 48'h2_0000_0000;
    repeat (40) @(posedge CLK);
    chk({31'h0, (TW_IN[0] - TW_OUT[0]) * 100 > 48'h1_0000_0000}, 32'h1);
    test_done;
  end
endmodule
`default_nettype wire

// ### verif/phase_source_model.sv
// phase detector stand-in: one error sample every gap+1 cycles while enabled
`timescale 1ns/1ps
`default_nettype none
module phase_source_model
  import dpll_lock_pkg::*;
(
  input wire logic clk,
  input wire logic en,
  input wire logic [3:0] gap,
  input wire logic signed [31:0] err,
  output var dpll_lock_pkg::phase_sample_t smp
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk) begin
    cnt_q <= (!en || cnt_q == gap) ? 4'h0 : cnt_q + 4'h1;
  end
  assign smp.valid = en && cnt_q == gap;
  // junk between samples so a stale error is never mistaken for a sample
  assign smp.err_ps = smp.valid ? err : ~err;
endmodule
`default_nettype wire
